/* ssr_top.sv */
/*
 * Speed search and auto restart sequencer for an inverter output stage.
 * Assumes all inputs are synchronous to clk_sys; currents in 0.1 A units,
 * delays in 0.1 s units; nominalVolt is the V/F voltage for the target frequency.
 */
`timescale 1ns/100ps
`include "ssr_regs.svh"
module ssr_top #(
    parameter int FW          = 16,
    parameter int VW          = 16,
    parameter int CW          = 12,
    parameter int RIDE_CYCLES = `SSR_RIDE_US * (`SSR_CLK_HZ / 1000000),
    parameter int TICK_CYCLES = `SSR_TICK_MS * (`SSR_CLK_HZ / 1000),
    parameter int PI_CYCLES   = `SSR_PI_US * (`SSR_CLK_HZ / 1000000)
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    input  wire logic [3:0]    searchModeSelect,
    input  wire logic [7:0]    searchCurrentLimit,
    input  wire logic [13:0]   searchPropGain,
    input  wire logic [13:0]   searchIntegralGain,
    input  wire logic [4:0]    multiOutputSelect,
    input  wire logic [4:0]    relayOutputSelect,
    input  wire logic [3:0]    restartAttemptCount,
    input  wire logic [9:0]    restartDelay,
    input  wire logic [10:0]   motorRatedCurrent,
    input  wire logic          powerOnStart,
    input  wire logic          restartAfterFaultReset,
    input  wire logic          runCmd,
    input  wire logic [FW-1:0] freqCmd,
    input  wire logic [VW-1:0] nominalVolt,
    input  wire logic [CW-1:0] outCurrent,
    input  wire logic          powerLost,
    input  wire logic          faultTrip,
    input  wire logic          emergencyStop,
    input  wire logic          overheatTrip,
    input  wire logic          hardwareTrip,
    input  wire logic          terminalReset,
    input  wire logic          keypadReset,
    output logic      [FW-1:0] outFreq,
    output logic      [VW-1:0] outVolt,
    output logic               outputHold,
    output logic               searchActive,
    output logic               multiFunctionOutput,
    output logic               relayContactOutput,
    output logic               undervoltageTrip,
    output logic      [3:0]    attemptsLeft,
    output logic               autoRestartEnabled
);
    localparam int QUIET_TICKS = `SSR_QUIET_SEC * 1000 / `SSR_TICK_MS;
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int RW = $clog2(RIDE_CYCLES + 1);
    localparam int PW = $clog2(PI_CYCLES + 1);
    localparam int EW = 21;
    localparam int SW = 8;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic selIsSearch(input logic [4:0] sel);
        return sel == `SSR_OUT_SEL_SEARCH;
    endfunction : selIsSearch

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ssr_pkg::ssr_state_t state_q, stateD;
    ssr_pkg::ssr_cause_t cause_q, causeD;
    logic [FW-1:0] freq_q, freqD, holdFreq_q, holdFreqD;
    logic [VW-1:0] volt_q, voltD;
    logic [3:0]    attempts_q, attemptsD;
    logic [9:0]    delayCnt_q, delayD;
    logic [8:0]    quietCnt_q, quietD;
    logic          quietRun_q, quietRunD;
    logic          first_q, firstD;
    logic [TW-1:0] tickCnt_q;
    logic [RW-1:0] rideCnt_q;
    logic [PW-1:0] piCnt_q;
    logic          hold_q, search_q, mfo_q, relay_q, uv_q;

    // ----------------------------------------------------------------
    // setting decode
    // ----------------------------------------------------------------
    logic [7:0]    cfgPct;
    logic [10:0]   cfgRated;
    logic [13:0]   cfgKp, cfgKi;
    logic [3:0]    cfgAttempts;
    logic [9:0]    cfgDelay;
    logic [19:0]   curScaled, limScaled;
    logic          overLimit, tenthTick, piTick, uvNow, blockTrip, tripAny, resetReq;
    logic          wantSearch, volt17Over;
    logic [VW:0]   voltSum;
    logic [SW-1:0] piStep;

    assign cfgPct = (searchCurrentLimit < `SSR_LIMIT_MIN) ? `SSR_LIMIT_MIN :
                    (searchCurrentLimit > `SSR_LIMIT_MAX) ? `SSR_LIMIT_MAX : searchCurrentLimit;
    assign cfgRated = (motorRatedCurrent < `SSR_RATED_MIN) ? `SSR_RATED_MIN :
                      (motorRatedCurrent > `SSR_RATED_MAX) ? `SSR_RATED_MAX : motorRatedCurrent;
    assign cfgKp = (searchPropGain > `SSR_GAIN_MAX) ? `SSR_GAIN_MAX : searchPropGain;
    assign cfgKi = (searchIntegralGain > `SSR_GAIN_MAX) ? `SSR_GAIN_MAX : searchIntegralGain;
    assign cfgAttempts = (restartAttemptCount > `SSR_ATTEMPT_MAX) ? `SSR_ATTEMPT_MAX
                                                                  : restartAttemptCount;
    assign cfgDelay = (restartDelay > `SSR_DELAY_MAX) ? `SSR_DELAY_MAX : restartDelay;

    // current is the only speed evidence
    assign curScaled = 20'(outCurrent) * `SSR_PCT_SCALE;
    assign limScaled = 20'(cfgRated) * 20'(cfgPct);
    assign overLimit = curScaled > limScaled;

    assign tenthTick = tickCnt_q == TW'(TICK_CYCLES - 1);
    assign piTick    = piCnt_q == PW'(PI_CYCLES - 1);
    assign uvNow     = powerLost && (rideCnt_q == RW'(RIDE_CYCLES - 1));
    assign blockTrip = uvNow || emergencyStop || overheatTrip || hardwareTrip;
    assign tripAny   = blockTrip || faultTrip;
    assign resetReq  = terminalReset || keypadReset;
    assign wantSearch = (first_q && powerOnStart) ? searchModeSelect[`SSR_MODE_PWRON_BIT]
                                                  : searchModeSelect[`SSR_MODE_ACCEL_BIT];
    assign voltSum    = {1'b0, volt_q} + (VW + 1)'(piStep);
    assign volt17Over = voltSum > {1'b0, nominalVolt};

    // ----------------------------------------------------------------
    // PI stepper
    // ----------------------------------------------------------------
    ssr_pi_if #(.GW(14), .EW(EW), .SW(SW)) piBus ();

    assign piBus.run  = state_q == ssr_pkg::S_SEARCH;
    assign piBus.tick = piTick;
    assign piBus.err  = $signed({1'b0, limScaled}) - $signed({1'b0, curScaled});
    assign piBus.kp   = cfgKp;
    assign piBus.ki   = cfgKi;
    assign piStep     = piBus.step;

    ssr_pi #(.GW(14), .EW(EW), .SW(SW)) uPi (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pi      (piBus)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        stateD    = state_q;
        causeD    = cause_q;
        freqD     = freq_q;
        holdFreqD = holdFreq_q;
        voltD     = volt_q;
        attemptsD = attempts_q;
        delayD    = delayCnt_q;
        quietD    = quietCnt_q;
        quietRunD = quietRun_q;
        firstD    = first_q;
        if (quietRun_q && tenthTick) begin
            if (quietCnt_q == 9'(QUIET_TICKS - 1)) begin
                attemptsD = cfgAttempts;
                quietRunD = 1'b0;
            end else begin
                quietD = quietCnt_q + 9'h001;
            end
        end
        unique case (state_q)
            ssr_pkg::S_IDLE: begin
                freqD     = '0;
                voltD     = '0;
                attemptsD = cfgAttempts;
                if (runCmd) begin
                    holdFreqD = freqCmd;
                    firstD    = 1'b0;
                    if (wantSearch) begin
                        stateD = ssr_pkg::S_SEARCH;
                        freqD  = freqCmd;
                    end else begin
                        stateD = ssr_pkg::S_ACCEL;
                    end
                end
            end
            ssr_pkg::S_RUN: begin
                freqD     = freqCmd;
                holdFreqD = freqCmd;
                voltD     = nominalVolt;
                if (!runCmd) begin
                    stateD = ssr_pkg::S_IDLE;
                end
            end
            ssr_pkg::S_ACCEL: begin
                voltD = nominalVolt;
                if (freq_q >= holdFreq_q) begin
                    stateD = ssr_pkg::S_RUN;
                end else if (piTick) begin
                    freqD = freq_q + 1'b1;
                end
                if (!runCmd) begin
                    stateD = ssr_pkg::S_IDLE;
                end
            end
            ssr_pkg::S_SEARCH: begin
                if (piTick) begin
                    if (overLimit) begin
                        if (freq_q != '0) begin
                            freqD = freq_q - 1'b1;
                        end
                    end else begin
                        voltD = volt17Over ? nominalVolt : voltSum[VW-1:0];
                    end
                end
                if (volt_q >= nominalVolt && !overLimit) begin
                    stateD = ssr_pkg::S_ACCEL;
                end
                if (!runCmd) begin
                    stateD = ssr_pkg::S_IDLE;
                end
            end
            ssr_pkg::S_HOLD: begin
                freqD = '0;
                voltD = '0;
                if (resetReq) begin
                    attemptsD = cfgAttempts;
                    quietRunD = 1'b0;
                    if (restartAfterFaultReset && runCmd) begin
                        if (searchModeSelect[`SSR_MODE_FAULT_BIT]) begin
                            stateD = ssr_pkg::S_SEARCH;
                            freqD  = holdFreq_q;
                        end else begin
                            stateD = ssr_pkg::S_ACCEL;
                        end
                    end else begin
                        stateD = ssr_pkg::S_IDLE;
                    end
                end else if (cause_q == ssr_pkg::C_UV && !powerLost) begin
                    if (searchModeSelect[`SSR_MODE_IPF_BIT] && runCmd) begin
                        stateD = ssr_pkg::S_SEARCH;
                        freqD  = holdFreq_q;
                    end else begin
                        stateD = ssr_pkg::S_IDLE;
                    end
                // only plain faults with attempts left retry
                end else if (cause_q == ssr_pkg::C_FAULT && attempts_q != 4'h0) begin
                    stateD = ssr_pkg::S_WAIT;
                    delayD = '0;
                end
            end
            ssr_pkg::S_WAIT: begin
                if (resetReq) begin
                    attemptsD = cfgAttempts;
                    stateD    = ssr_pkg::S_IDLE;
                end else if (delayCnt_q >= cfgDelay) begin
                    stateD    = ssr_pkg::S_SEARCH;
                    freqD     = holdFreq_q;
                    voltD     = '0;
                    attemptsD = attempts_q - 4'h1;
                    quietRunD = 1'b1;
                    quietD    = '0;
                end else if (tenthTick) begin
                    delayD = delayCnt_q + 10'h001;
                end
            end
            default: begin
                stateD = ssr_pkg::S_IDLE;
            end
        endcase
        // trips take precedence outside S_HOLD and stop the output
        if (tripAny && state_q != ssr_pkg::S_HOLD) begin
            stateD    = ssr_pkg::S_HOLD;
            causeD    = uvNow ? ssr_pkg::C_UV : blockTrip ? ssr_pkg::C_BLOCK : ssr_pkg::C_FAULT;
            quietRunD = 1'b0;
            freqD     = '0;
            voltD     = '0;
            if (state_q == ssr_pkg::S_RUN || state_q == ssr_pkg::S_ACCEL ||
                state_q == ssr_pkg::S_SEARCH) begin
                holdFreqD = freq_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tickCnt_q <= '0;
            piCnt_q   <= '0;
            rideCnt_q <= '0;
        end else begin
            tickCnt_q <= tenthTick ? '0 : tickCnt_q + 1'b1;
            piCnt_q   <= piTick ? '0 : piCnt_q + 1'b1;
            // saturating, so the trip stays asserted while power stays away
            rideCnt_q <= !powerLost ? '0 : uvNow ? rideCnt_q : rideCnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ssr_pkg::S_IDLE;
            cause_q    <= ssr_pkg::C_NONE;
            freq_q     <= '0;
            holdFreq_q <= '0;
            volt_q     <= '0;
            attempts_q <= 4'h0;
            delayCnt_q <= '0;
            quietCnt_q <= '0;
            quietRun_q <= 1'b0;
            first_q    <= 1'b1;
        end else begin
            state_q    <= stateD;
            cause_q    <= causeD;
            freq_q     <= freqD;
            holdFreq_q <= holdFreqD;
            volt_q     <= voltD;
            attempts_q <= attemptsD;
            delayCnt_q <= delayD;
            quietCnt_q <= quietD;
            quietRun_q <= quietRunD;
            first_q    <= firstD;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hold_q   <= 1'b1;
            search_q <= 1'b0;
            mfo_q    <= 1'b0;
            relay_q  <= 1'b0;
            uv_q     <= 1'b0;
        end else begin
            hold_q   <= stateD == ssr_pkg::S_IDLE || stateD == ssr_pkg::S_HOLD ||
                        stateD == ssr_pkg::S_WAIT;
            search_q <= stateD == ssr_pkg::S_SEARCH;
            mfo_q    <= selIsSearch(multiOutputSelect) && stateD == ssr_pkg::S_SEARCH;
            relay_q  <= selIsSearch(relayOutputSelect) && stateD == ssr_pkg::S_SEARCH;
            uv_q     <= stateD == ssr_pkg::S_HOLD && causeD == ssr_pkg::C_UV;
        end
    end

    assign outFreq             = freq_q;
    assign outVolt             = volt_q;
    assign outputHold          = hold_q;
    assign searchActive        = search_q;
    assign multiFunctionOutput = mfo_q;
    assign relayContactOutput  = relay_q;
    assign undervoltageTrip    = uv_q;
    assign attemptsLeft        = attempts_q;
    assign autoRestartEnabled  = attempts_q != 4'h0;

endmodule : ssr_top

/* ssr_regs.svh */
/*
 * Constants for the speed search and auto restart sequencer: setting fields,
 * setting ranges and timing figures.
 * Assumes a 40 MHz system clock; settings arrive as plain, already-synchronous ports.
 */
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

`define SSR_MODE_ACCEL_BIT  0
`define SSR_MODE_FAULT_BIT  1
`define SSR_MODE_IPF_BIT    2
`define SSR_MODE_PWRON_BIT  3

`define SSR_OUT_SEL_SEARCH  5'h0F

`define SSR_LIMIT_MIN       8'h50
`define SSR_LIMIT_MAX       8'hC8
`define SSR_PCT_SCALE       20'h00064
`define SSR_GAIN_MAX        14'h270F
`define SSR_ATTEMPT_MAX     4'hA
`define SSR_DELAY_MAX       10'h258
`define SSR_RATED_MIN       11'h005
`define SSR_RATED_MAX       11'h5DC

`define SSR_PI_SHIFT        8

`define SSR_CLK_HZ          40000000
`define SSR_RIDE_US         15000
`define SSR_TICK_MS         100
`define SSR_QUIET_SEC       30
`define SSR_PI_US           100

`endif

/* ssr_pkg.sv */
/*
 * Types shared by the speed search and auto restart sequencer.
 * Assumes nothing beyond the compile order: this file before the modules.
 */
package ssr_pkg;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_RUN    = 3'b001,
        S_ACCEL  = 3'b010,
        S_SEARCH = 3'b011,
        S_HOLD   = 3'b100,
        S_WAIT   = 3'b101
    } ssr_state_t;

    typedef enum logic [1:0] {
        C_NONE  = 2'b00,
        C_UV    = 2'b01,
        C_BLOCK = 2'b10,
        C_FAULT = 2'b11
    } ssr_cause_t;

endpackage : ssr_pkg

/* ssr_pi_if.sv */
/*
 * Carrier between the sequencer and its PI voltage stepper.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface ssr_pi_if #(
    parameter int GW = 14,
    parameter int EW = 21,
    parameter int SW = 8
);
    logic                 run;
    logic                 tick;
    logic signed [EW-1:0] err;
    logic        [GW-1:0] kp;
    logic        [GW-1:0] ki;
    logic        [SW-1:0] step;

    modport ctl (output run, output tick, output err, output kp, output ki, input step);
    modport pi  (input run, input tick, input err, input kp, input ki, output step);
endinterface : ssr_pi_if

/* ssr_pi.sv */
/*
 * PI stepper: turns the current margin into a voltage increment per update.
 * Assumes err is positive while current is below the limit.
 */
`timescale 1ns/100ps
module ssr_pi #(
    parameter int GW = 14,
    parameter int EW = 21,
    parameter int SW = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    ssr_pi_if.pi     pi
);
    localparam int MW = EW + GW + 1;
    localparam int AW = MW + 4;

    logic signed [MW-1:0] pTerm;
    logic signed [MW-1:0] iTerm;
    logic signed [AW-1:0] integ_q;
    logic signed [AW-1:0] integ_d;
    logic signed [AW-1:0] sum;
    logic signed [AW-1:0] scaled;
    logic        [SW-1:0] step_q;
    logic        [SW-1:0] step_d;

    // ----------------------------------------------------------------
    // proportional and integral terms
    // ----------------------------------------------------------------
    // PI gains applied
    assign pTerm   = pi.err * $signed({1'b0, pi.kp});
    assign iTerm   = pi.err * $signed({1'b0, pi.ki});
    // floor at zero keeps the integrator from winding far below
    assign integ_d = (integ_q + AW'(iTerm) < 0) ? '0 : integ_q + AW'(iTerm);
    assign sum     = AW'(pTerm) + integ_d;
    assign scaled  = sum >>> `SSR_PI_SHIFT;
    assign step_d  = (scaled < 0) ? '0 :
                     (scaled > AW'({SW{1'b1}})) ? {SW{1'b1}} : scaled[SW-1:0];
    assign pi.step = step_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            integ_q <= '0;
            step_q  <= '0;
        end else if (!pi.run) begin
            integ_q <= '0;
            step_q  <= '0;
        end else if (pi.tick) begin
            integ_q <= integ_d;
            step_q  <= step_d;
        end
    end

endmodule : ssr_pi

/* ssr_motor.sv */
/* motor and load seen through the power stage: current only.
   assumes the bench picks the load; no current while output is held. */
`timescale 1ns/100ps
module ssr_motor (
    input  wire logic        outputHold,
    input  wire logic        heavy,
    output logic      [11:0] outCurrent
);
    // ------------------------------
    // load current
    // ------------------------------
    // current is the only speed clue
    // a heavy load reads 20 A, twice a 10 A rating
    assign outCurrent = outputHold ? 12'h000 : (heavy ? 12'h0C8 : 12'h032);
endmodule : ssr_motor

/* ssr_top_chk.sv */
/* port assertions for the speed search and restart sequencer.
   assumes settings stay in range and only the retry path lowers the count. */
`timescale 1ns/100ps
module ssr_top_chk #(
    parameter int RIDE_CYCLES = 20
) (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [4:0]  multiOutputSelect,
    input wire logic [7:0]  searchCurrentLimit,
    input wire logic [10:0] motorRatedCurrent,
    input wire logic [11:0] outCurrent,
    input wire logic [15:0] nominalVolt,
    input wire logic        powerLost,
    input wire logic        hardwareTrip,
    input wire logic [15:0] outFreq,
    input wire logic [15:0] outVolt,
    input wire logic        outputHold,
    input wire logic        searchActive,
    input wire logic        multiFunctionOutput,
    input wire logic        undervoltageTrip,
    input wire logic [3:0]  attemptsLeft,
    input wire logic        autoRestartEnabled
);
    // ------------------------------
    // properties
    // ------------------------------
    localparam int RIDE_MAX = RIDE_CYCLES + 4;
    logic over;
    assign over = outCurrent * 20'h00064 > motorRatedCurrent * searchCurrentLimit;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence overStep; searchActive && over ##1 searchActive; endsequence
    sequence underStep; searchActive && !over ##1 searchActive; endsequence
    count_range_a: assert property (attemptsLeft <= 4'hA)
        else $error("attempt count above ten");
    enable_count_a: assert property (autoRestartEnabled == (attemptsLeft != 4'h0))
        else $error("restart enable does not follow count");
    count_step_a: assert property ($past(attemptsLeft) > attemptsLeft |->
        $fell(outputHold) && attemptsLeft == $past(attemptsLeft) - 4'h1)
        else $error("attempt count dropped wrongly");
    uv_hold_a: assert property (undervoltageTrip |-> outputHold && outVolt == 16'h0000)
        else $error("undervoltage trip without held output");
    ride_through_a: assert property ($rose(powerLost) && !outputHold |->
        !undervoltageTrip [*8] ##[1:RIDE_MAX] (undervoltageTrip || !powerLost))
        else $error("power loss handled at wrong time");
    over_step_a: assert property (overStep |->
        outVolt <= $past(outVolt) && outFreq <= $past(outFreq))
        else $error("voltage rose or freq rose over limit");
    under_step_a: assert property (underStep |->
        outVolt >= $past(outVolt) && outFreq == $past(outFreq))
        else $error("voltage fell or freq moved under limit");
    search_end_a: assert property ($fell(searchActive) && !outputHold |->
        $past(outVolt) >= $past(nominalVolt))
        else $error("search ended below target voltage");
    block_hold_a: assert property ($rose(hardwareTrip) && !outputHold |=> outputHold [*8])
        else $error("restart after hardware trip");
    search_out_a: assert property (searchActive && $past(searchActive) &&
        multiOutputSelect == 5'h0F && $past(multiOutputSelect) == 5'h0F |-> multiFunctionOutput)
        else $error("search output missing");
endmodule : ssr_top_chk
bind ssr_top ssr_top_chk #(.RIDE_CYCLES(RIDE_CYCLES)) ssr_top_chk_inst (.clk_sys, .rst_b,
    .multiOutputSelect, .searchCurrentLimit, .motorRatedCurrent, .outCurrent, .nominalVolt,
    .powerLost, .hardwareTrip, .outFreq, .outVolt, .outputHold, .searchActive,
    .multiFunctionOutput, .undervoltageTrip, .attemptsLeft, .autoRestartEnabled);

/* ssr_top_test.sv */
/* bench for the speed search and restart sequencer.
   assumes short sim counts: ride 20, tick 10, pi 2 cycles. */
`timescale 1ns/100ps
module ssr_top_test;
    // ------------------------------
    // stimulus and checks
    // ------------------------------
    logic        clk_sys = 1'b0, rst_b = 1'b0, heavy = 1'b0, runCmd = 1'b0, powerLost = 1'b0;
    logic        faultTrip = 1'b0, emergencyStop = 1'b0, overheatTrip = 1'b0;
    logic        hardwareTrip = 1'b0, terminalReset = 1'b0, keypadReset = 1'b0;
    logic        powerOnStart = 1'b0, restartAfterFaultReset = 1'b0;
    logic [3:0]  searchModeSelect = 4'hF, restartAttemptCount = 4'h2;
    logic [7:0]  searchCurrentLimit = 8'h64;
    logic [13:0] searchPropGain = 14'h0064, searchIntegralGain = 14'h00C8;
    logic [4:0]  multiOutputSelect = 5'h0F, relayOutputSelect = 5'h0E;
    logic [9:0]  restartDelay = 10'h002;
    logic [10:0] motorRatedCurrent = 11'h064;
    logic [15:0] freqCmd = 16'h0100, nominalVolt = 16'h0040, outFreq, outVolt;
    logic [11:0] outCurrent;
    logic [3:0]  attemptsLeft;
    logic        outputHold, searchActive, multiFunctionOutput, relayContactOutput;
    logic        undervoltageTrip, autoRestartEnabled;
    int          fails = 0;
    int          comparisons = 0;
    always #12.5 clk_sys = ~clk_sys;
    ssr_top #(.RIDE_CYCLES(20), .TICK_CYCLES(10), .PI_CYCLES(2)) ssr_top_inst (.clk_sys, .rst_b,
        .searchModeSelect, .searchCurrentLimit, .searchPropGain, .searchIntegralGain,
        .multiOutputSelect, .relayOutputSelect, .restartAttemptCount, .restartDelay,
        .motorRatedCurrent, .powerOnStart, .restartAfterFaultReset, .runCmd, .freqCmd,
        .nominalVolt, .outCurrent, .powerLost, .faultTrip, .emergencyStop, .overheatTrip,
        .hardwareTrip, .terminalReset, .keypadReset, .outFreq, .outVolt, .outputHold,
        .searchActive, .multiFunctionOutput, .relayContactOutput, .undervoltageTrip,
        .attemptsLeft, .autoRestartEnabled);
    ssr_motor ssr_motor_inst (.outputHold, .heavy, .outCurrent);
    task automatic summarize();
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : step
    // sel 0 search flag, 2 running at target; bounded so a hang ends the run
    task automatic waitOn(input int sel);
        int n;
        n = 0;
        while (n < 5000 && (sel == 0 ? searchActive : outFreq == freqCmd && !searchActive) !== 1'b1) begin
            step(1);
            n++;
        end
        if (n == 5000) begin
            fails++;
            summarize();
        end
    endtask : waitOn
    task automatic trip();
        faultTrip = 1'b1;
        step(1);
        faultTrip = 1'b0;
    endtask : trip
    initial begin
        int i;
        step(20);
        rst_b = 1'b1;
        runCmd = 1'b1;
        step(1);
        chk("search", 16'h0001, searchActive);
        chk("freq", freqCmd, outFreq);
        chk("mfo", 16'h0001, multiFunctionOutput);
        chk("relay", 16'h0000, relayContactOutput);
        heavy = 1'b1;
        step(6);
        heavy = 1'b0;
        chk("lowered", 16'h0001, outFreq < freqCmd);
        waitOn(2);
        chk("volt", nominalVolt, outVolt);
        trip();
        chk("hold", 16'h0001, outputHold);
        chk("volt", 16'h0000, outVolt);
        step(5);
        chk("wait", 16'h0001, outputHold);
        waitOn(0);
        chk("left", 16'h0001, attemptsLeft);
        chk("freq", freqCmd, outFreq);
        waitOn(2);
        step(2950);
        chk("left", 16'h0001, attemptsLeft);
        step(150);
        chk("left", 16'h0002, attemptsLeft);
        for (i = 0; i < 2; i++) begin
            trip();
            waitOn(2);
        end
        chk("left", 16'h0000, attemptsLeft);
        trip();
        step(60);
        chk("hold", 16'h0001, outputHold);
        chk("enable", 16'h0000, autoRestartEnabled);
        keypadReset = 1'b1;
        step(1);
        keypadReset = 1'b0;
        step(1);
        chk("left", 16'h0002, attemptsLeft);
        waitOn(2);
        powerLost = 1'b1;
        step(5);
        powerLost = 1'b0;
        step(2);
        chk("uv", 16'h0000, undervoltageTrip);
        chk("freq", freqCmd, outFreq);
        powerLost = 1'b1;
        step(30);
        chk("uv", 16'h0001, undervoltageTrip);
        powerLost = 1'b0;
        relayOutputSelect = 5'h0F;
        step(1);
        chk("search", 16'h0001, searchActive);
        chk("relay", 16'h0001, relayContactOutput);
        chk("freq", freqCmd, outFreq);
        waitOn(2);
        for (i = 0; i < 5; i++) begin
            searchModeSelect = (i < 3) ? 4'hF : ((i == 3) ? 4'h2 : 4'h0);
            restartAfterFaultReset = (i > 2);
            {emergencyStop, overheatTrip, hardwareTrip} = (i < 3) ? (3'h1 << i) : 3'h1;
            step(1);
            {emergencyStop, overheatTrip, hardwareTrip} = 3'h0;
            step(60);
            chk("hold", 16'h0001, outputHold);
            chk("left", 16'h0002, attemptsLeft);
            terminalReset = 1'b1;
            step(1);
            terminalReset = 1'b0;
            if (i > 2) chk("mode", searchModeSelect[1], searchActive);
            waitOn(2);
        end
        // power-on start needs a fresh reset: only the first start uses bit 3
        searchModeSelect = 4'h8;
        powerOnStart = 1'b1;
        rst_b = 1'b0;
        step(2);
        chk("rstHold", 16'h0001, outputHold);
        rst_b = 1'b1;
        step(1);
        chk("pwron", 16'h0001, searchActive);
        summarize();
    end
endmodule : ssr_top_test
